// ==== ifs_pkg.sv ====
package ifs_pkg;

  // Process value width, signed whole units
  localparam int VALUE_W = 16;
  localparam int EXT_W = 18;

  // Control range margins for temperature inputs
  localparam logic signed [EXT_W-1:0] TEMP_MARGIN_C = 18'sh0_0014;
  localparam logic signed [EXT_W-1:0] TEMP_MARGIN_F = 18'sh0_0028;

  // Analog margin is span / 20, i.e. 5 percent below and above
  localparam logic signed [EXT_W-1:0] ANALOG_MARGIN_DIV = 18'sh0_0014;

  // Display range limits
  localparam logic signed [EXT_W-1:0] DISP_MIN = 18'sh3_F831;
  localparam logic signed [EXT_W-1:0] DISP_MAX = 18'sh0_270F;

  // Cause bit positions on fault_cause_o
  localparam int CAUSE_RANGE = 0;
  localparam int CAUSE_TYPE = 1;
  localparam int CAUSE_OPEN = 2;
  localparam int CAUSE_SHORT = 3;
  localparam int CAUSE_W = 4;

  typedef enum logic [1:0] {
    IFS_IN_THERMOCOUPLE = 2'h0,
    IFS_IN_RESISTANCE = 2'h1,
    IFS_IN_ANALOG = 2'h2,
    IFS_IN_INFRARED = 2'h3
  } ifs_input_type;

  typedef enum logic [4:0] {
    IFS_DISP_NUMERIC = 5'h01,
    IFS_DISP_INPUT_FAULT = 5'h02,
    IFS_DISP_UNDER = 5'h04,
    IFS_DISP_OVER = 5'h08,
    IFS_DISP_CONVERTER_FAULT = 5'h10
  } ifs_disp_type;

  typedef enum logic [2:0] {
    IFS_ST_NORMAL = 3'h1,
    IFS_ST_INPUT_FAULT = 3'h2,
    IFS_ST_CONV_FAULT = 3'h4
  } ifs_state_type;

endpackage : ifs_pkg

// ==== ifs_range_check.sv ====
`timescale 1ns/1ps

module ifs_range_check (
  input wire ifs_pkg::ifs_input_type input_type_i,
  input wire logic fahrenheit_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] pv_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] sp_low_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] sp_high_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] scale_low_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] scale_high_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] ind_low_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] ind_high_i,
  output logic out_of_range_o,
  output logic below_display_o,
  output logic above_display_o
);
  import ifs_pkg::*;

  logic signed [EXT_W-1:0] pv;
  logic signed [EXT_W-1:0] lo;
  logic signed [EXT_W-1:0] hi;
  logic signed [EXT_W-1:0] span;
  logic signed [EXT_W-1:0] margin;

  always_comb begin
    pv = EXT_W'(pv_i);
    span = EXT_W'(scale_high_i) - EXT_W'(scale_low_i);
    margin = fahrenheit_i ? TEMP_MARGIN_F : TEMP_MARGIN_C;
    lo = EXT_W'(sp_low_i) - margin;
    hi = EXT_W'(sp_high_i) + margin;
    case (input_type_i)
      IFS_IN_ANALOG: begin
        lo = EXT_W'(scale_low_i) - span / ANALOG_MARGIN_DIV;
        hi = EXT_W'(scale_high_i) + span / ANALOG_MARGIN_DIV;
      end
      IFS_IN_INFRARED: begin
        lo = EXT_W'(ind_low_i);
        hi = EXT_W'(ind_high_i);
      end
      default: begin
      end
    endcase
    out_of_range_o = (pv < lo) || (pv > hi);
    below_display_o = pv < DISP_MIN;
    above_display_o = pv > DISP_MAX;
  end

endmodule : ifs_range_check

// ==== ifs_supervisor.sv ====
`timescale 1ns/1ps

module ifs_supervisor #(
  parameter int ALARM_N = 4,
  parameter int AUX_N = 4,
  parameter int CTRL_N = 2,
  parameter int MV_W = 16
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire ifs_pkg::ifs_input_type input_type_i,
  input wire logic fahrenheit_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] pv_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] sp_low_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] sp_high_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] scale_low_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] scale_high_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] ind_low_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] ind_high_i,
  input wire logic type_mismatch_i,
  input wire logic sensor_open_i,
  input wire logic sensor_short_i,
  input wire logic [2:0] rtd_line_open_i,
  input wire logic converter_fault_i,
  input wire logic [ALARM_N-1:0] alarm_normal_i,
  input wire logic [ALARM_N-1:0] alarm_upper_i,
  input wire logic [AUX_N-1:0] aux_normal_i,
  input wire logic [AUX_N-1:0] aux_fault_assign_i,
  input wire logic [CTRL_N-1:0] ctrl_normal_i,
  input wire logic [CTRL_N-1:0] ctrl_fault_assign_i,
  input wire logic [ifs_pkg::VALUE_W-1:0] transfer_normal_i,
  input wire logic [ifs_pkg::VALUE_W-1:0] transfer_upper_i,
  input wire logic [MV_W-1:0] heat_mv_i,
  input wire logic [MV_W-1:0] cool_mv_i,
  input wire logic manual_mode_i,
  input wire logic [MV_W-1:0] manual_mv_i,
  input wire logic in_reset_i,
  input wire logic value_while_reset_en_i,
  input wire logic [MV_W-1:0] output_value_while_reset_i,
  input wire logic value_on_fault_en_i,
  input wire logic [MV_W-1:0] output_value_on_process_fault_i,
  output logic input_fault_o,
  output logic converter_fault_code_o,
  output logic [ifs_pkg::CAUSE_W-1:0] fault_cause_o,
  output ifs_pkg::ifs_disp_type disp_code_o,
  output logic signed [ifs_pkg::VALUE_W-1:0] disp_value_o,
  output logic [ALARM_N-1:0] alarm_o,
  output logic [AUX_N-1:0] aux_o,
  output logic [CTRL_N-1:0] ctrl_o,
  output logic [ifs_pkg::VALUE_W-1:0] transfer_o,
  output logic [MV_W-1:0] heat_mv_o,
  output logic [MV_W-1:0] cool_mv_o
);
  import ifs_pkg::*;

  typedef struct packed {
    ifs_state_type mode;
    logic input_fault;
    logic conv_fault;
    logic [CAUSE_W-1:0] cause;
    ifs_disp_type disp;
    logic signed [VALUE_W-1:0] disp_value;
    logic [ALARM_N-1:0] alarm;
    logic [AUX_N-1:0] aux;
    logic [CTRL_N-1:0] ctrl;
    logic [VALUE_W-1:0] transfer;
    logic [MV_W-1:0] heat;
    logic [MV_W-1:0] cool;
  } ifs_reg_type;

  localparam ifs_reg_type RESET_STATE = '{
    mode: IFS_ST_NORMAL,
    input_fault: 1'b0,
    conv_fault: 1'b0,
    cause: '0,
    disp: IFS_DISP_NUMERIC,
    disp_value: '0,
    alarm: '0,
    aux: '0,
    ctrl: '0,
    transfer: '0,
    heat: '0,
    cool: '0
  };

  ifs_reg_type st;
  ifs_reg_type next_st;

  logic out_of_range;
  logic below_display;
  logic above_display;
  logic disconnected;
  logic [CAUSE_W-1:0] cause_now;
  logic fault_now;
  logic [MV_W-1:0] hold_mv;
  logic hold_en;

  ////////////////////////////////////////////////////////////////////////////
  // Range evaluation

  ifs_range_check u_range (
    .input_type_i(input_type_i),
    .fahrenheit_i(fahrenheit_i),
    .pv_i(pv_i),
    .sp_low_i(sp_low_i),
    .sp_high_i(sp_high_i),
    .scale_low_i(scale_low_i),
    .scale_high_i(scale_high_i),
    .ind_low_i(ind_low_i),
    .ind_high_i(ind_high_i),
    .out_of_range_o(out_of_range),
    .below_display_o(below_display),
    .above_display_o(above_display)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fault decision and output forcing

  always_comb begin
    next_st = st;
    disconnected = sensor_open_i;
    if (input_type_i == IFS_IN_RESISTANCE && |rtd_line_open_i) begin
      disconnected = 1'b1;
    end
    cause_now = '0;
    cause_now[CAUSE_RANGE] = out_of_range;
    cause_now[CAUSE_TYPE] = type_mismatch_i;
    cause_now[CAUSE_OPEN] = disconnected;
    cause_now[CAUSE_SHORT] = sensor_short_i;
    fault_now = |cause_now;

    // Configured hold value, manual first, then reset, then fault value
    hold_en = 1'b1;
    hold_mv = manual_mv_i;
    if (manual_mode_i) begin
      hold_mv = manual_mv_i;
    end else if (in_reset_i && value_while_reset_en_i) begin
      hold_mv = output_value_while_reset_i;
    end else if (value_on_fault_en_i) begin
      hold_mv = output_value_on_process_fault_i;
    end else begin
      hold_en = 1'b0;
    end

    // Converter fault outranks every input fault
    // Status flags kept as their own flops so the outputs need no decoding
    if (converter_fault_i) begin
      next_st.mode = IFS_ST_CONV_FAULT;
      next_st.input_fault = 1'b0;
      next_st.conv_fault = 1'b1;
    end else if (fault_now) begin
      next_st.mode = IFS_ST_INPUT_FAULT;
      next_st.input_fault = 1'b1;
      next_st.conv_fault = 1'b0;
    end else begin
      next_st.mode = IFS_ST_NORMAL;
      next_st.input_fault = 1'b0;
      next_st.conv_fault = 1'b0;
    end

    next_st.cause = cause_now;
    next_st.disp_value = pv_i;

    case (next_st.mode)
      IFS_ST_CONV_FAULT: begin
        next_st.disp = IFS_DISP_CONVERTER_FAULT;
        next_st.alarm = '0;
        next_st.aux = '0;
        next_st.ctrl = '0;
        next_st.transfer = '0;
        next_st.heat = '0;
        next_st.cool = '0;
      end
      IFS_ST_INPUT_FAULT: begin
        next_st.disp = IFS_DISP_INPUT_FAULT;
        next_st.alarm = alarm_upper_i;
        next_st.transfer = transfer_upper_i;
        next_st.aux = aux_fault_assign_i;
        next_st.ctrl = ctrl_fault_assign_i;
        next_st.heat = hold_en ? hold_mv : '0;
        next_st.cool = '0;
      end
      default: begin
        if (below_display) begin
          next_st.disp = IFS_DISP_UNDER;
        end else if (above_display) begin
          next_st.disp = IFS_DISP_OVER;
        end else begin
          next_st.disp = IFS_DISP_NUMERIC;
        end
        next_st.alarm = alarm_normal_i;
        next_st.aux = aux_normal_i;
        next_st.ctrl = ctrl_normal_i;
        next_st.transfer = transfer_normal_i;
        next_st.heat = heat_mv_i;
        next_st.cool = cool_mv_i;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      st <= RESET_STATE;
    end else begin
      st <= next_st;
    end
  end

  assign input_fault_o = st.input_fault;
  assign converter_fault_code_o = st.conv_fault;
  assign fault_cause_o = st.cause;
  assign disp_code_o = st.disp;
  assign disp_value_o = st.disp_value;
  assign alarm_o = st.alarm;
  assign aux_o = st.aux;
  assign ctrl_o = st.ctrl;
  assign transfer_o = st.transfer;
  assign heat_mv_o = st.heat;
  assign cool_mv_o = st.cool;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_TEMP_RANGE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (!converter_fault_i && !fahrenheit_i && input_type_i == IFS_IN_THERMOCOUPLE
     && (EXT_W'(pv_i) > EXT_W'(sp_high_i) + TEMP_MARGIN_C))
    |=> input_fault_o && fault_cause_o[CAUSE_RANGE])
  else $error("temperature above upper limit plus margin not flagged");

  AST_TEMP_RANGE_F: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (!converter_fault_i && fahrenheit_i && input_type_i == IFS_IN_THERMOCOUPLE
     && (EXT_W'(pv_i) > EXT_W'(sp_high_i) + TEMP_MARGIN_F))
    |=> input_fault_o && fault_cause_o[CAUSE_RANGE])
  else $error("fahrenheit temperature above upper limit plus margin not flagged");

  AST_TEMP_INSIDE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (input_type_i == IFS_IN_RESISTANCE && !fahrenheit_i
     && EXT_W'(pv_i) >= EXT_W'(sp_low_i) - TEMP_MARGIN_C
     && EXT_W'(pv_i) <= EXT_W'(sp_high_i) + TEMP_MARGIN_C)
    |=> !fault_cause_o[CAUSE_RANGE])
  else $error("temperature inside margin flagged as out of range");

  AST_ANALOG_RANGE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (input_type_i == IFS_IN_ANALOG && !converter_fault_i && scale_high_i > scale_low_i
     && int'(ANALOG_MARGIN_DIV) * (int'(pv_i) - int'(scale_low_i))
        < int'(scale_low_i) - int'(scale_high_i))
    |=> input_fault_o && fault_cause_o[CAUSE_RANGE])
  else $error("analog value below minus five percent not flagged");

  AST_IR_RANGE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (input_type_i == IFS_IN_INFRARED && pv_i > ind_high_i) |=> fault_cause_o[CAUSE_RANGE])
  else $error("infrared value above indication range not flagged");

  AST_TYPE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (type_mismatch_i && !converter_fault_i) |=> input_fault_o && fault_cause_o[CAUSE_TYPE])
  else $error("input type mismatch did not raise input fault");

  AST_OPEN_SHORT: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    ((sensor_open_i || sensor_short_i) && !converter_fault_i) |=> input_fault_o)
  else $error("open or shorted sensor did not raise input fault");

  AST_RTD_LINE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (input_type_i == IFS_IN_RESISTANCE && |rtd_line_open_i) |=> fault_cause_o[CAUSE_OPEN])
  else $error("resistance line break not seen as disconnection");

  AST_ALARM_UPPER: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    input_fault_o |-> alarm_o == $past(alarm_upper_i))
  else $error("alarm outputs not at upper limit state during input fault");

  AST_TRANSFER_UPPER: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    input_fault_o |-> transfer_o == $past(transfer_upper_i))
  else $error("transfer output not at upper value during input fault");

  AST_ASSIGNED_ON: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    input_fault_o |-> ((aux_o & $past(aux_fault_assign_i)) == $past(aux_fault_assign_i))
      && ((ctrl_o & $past(ctrl_fault_assign_i)) == $past(ctrl_fault_assign_i)))
  else $error("output assigned to input fault not on");

  AST_FAULT_DISPLAY: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    input_fault_o |-> disp_code_o == IFS_DISP_INPUT_FAULT)
  else $error("input fault code not displayed");

  AST_DEFAULT_OFF: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (input_fault_o && !$past(manual_mode_i) && !$past(value_on_fault_en_i)
     && !($past(in_reset_i) && $past(value_while_reset_en_i)))
    |-> heat_mv_o == '0 && cool_mv_o == '0)
  else $error("heating or cooling output on during input fault");

  AST_HOLD_VALUE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (fault_now && !converter_fault_i && value_on_fault_en_i && !manual_mode_i && !in_reset_i)
    ##1 input_fault_o |-> heat_mv_o == $past(output_value_on_process_fault_i))
  else $error("configured fault output value not applied");

  AST_HOLD_MANUAL: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (fault_now && !converter_fault_i && manual_mode_i)
    ##1 input_fault_o |-> heat_mv_o == $past(manual_mv_i))
  else $error("manual output value not applied during input fault");

  AST_HOLD_RESET: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (fault_now && !converter_fault_i && !manual_mode_i && in_reset_i
     && value_while_reset_en_i)
    ##1 input_fault_o |-> heat_mv_o == $past(output_value_while_reset_i))
  else $error("reset output value not applied during input fault");

  AST_NORMAL_PASS: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (!fault_now && !converter_fault_i)
    |=> !input_fault_o && alarm_o == $past(alarm_normal_i)
      && transfer_o == $past(transfer_normal_i) && cool_mv_o == $past(cool_mv_i))
  else $error("outputs disturbed without any fault");

  AST_OVER_RANGE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (above_display && !fault_now && !converter_fault_i)
    |=> disp_code_o == IFS_DISP_OVER && !input_fault_o && heat_mv_o == $past(heat_mv_i))
  else $error("over range not shown or disturbed control");

  AST_UNDER_RANGE: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    (below_display && !fault_now && !converter_fault_i)
    |=> disp_code_o == IFS_DISP_UNDER && ctrl_o == $past(ctrl_normal_i))
  else $error("under range not shown or disturbed control");

  AST_CONVERTER_OFF: assert property (
    @(posedge clock_i) disable iff (!reset_n_i)
    converter_fault_i |=> disp_code_o == IFS_DISP_CONVERTER_FAULT && alarm_o == '0
      && aux_o == '0 && ctrl_o == '0 && transfer_o == '0 && heat_mv_o == '0
      && cool_mv_o == '0)
  else $error("converter fault left an output on");

endmodule : ifs_supervisor

// ==== ifs_sensor_model.sv ====
`timescale 1ns/1ps

module ifs_sensor_model (
  input wire logic clock_i,
  input wire logic signed [ifs_pkg::VALUE_W-1:0] temp_i,
  input wire logic open_i,
  output logic signed [ifs_pkg::VALUE_W-1:0] pv_o
);
  import ifs_pkg::*;
  logic signed [VALUE_W-1:0] noise = 16'h5a5a;
  ////////////////////////////////////////////////////////////////
  // An open sensor gives no valid reading: it wanders every cycle
  always_ff @(posedge clock_i) begin
    noise <= ~noise;
  end
  assign pv_o = open_i ? noise : temp_i;
endmodule : ifs_sensor_model

// ==== test_input_fault_supervisor.sv ====
`timescale 1ns/1ps

module test_input_fault_supervisor;
  import ifs_pkg::*;
  logic clock_i = 1'b0, reset_n_i = 1'b0, fahrenheit_i = 1'b0, type_mismatch_i = 1'b0;
  logic sensor_open_i = 1'b0, sensor_short_i = 1'b0, converter_fault_i = 1'b0;
  logic manual_mode_i = 1'b0, in_reset_i = 1'b0, value_while_reset_en_i = 1'b0;
  logic value_on_fault_en_i = 1'b0, input_fault_o, converter_fault_code_o;
  ifs_input_type input_type_i = IFS_IN_THERMOCOUPLE;
  ifs_disp_type disp_code_o;
  logic signed [VALUE_W-1:0] pv_i, disp_value_o, temp = 16'h0032;
  logic signed [VALUE_W-1:0] sp_low_i = 16'h0000, sp_high_i = 16'h0064;
  logic signed [VALUE_W-1:0] scale_low_i = 16'h0000, scale_high_i = 16'h03e8;
  logic signed [VALUE_W-1:0] ind_low_i = 16'hff9c, ind_high_i = 16'h01f4;
  logic [2:0] rtd_line_open_i = 3'h0;
  logic [3:0] alarm_normal_i = 4'h0, alarm_upper_i = 4'h0, aux_normal_i = 4'h0;
  logic [3:0] aux_fault_assign_i = 4'h0, alarm_o, aux_o, fault_cause_o;
  logic [1:0] ctrl_normal_i = 2'h0, ctrl_fault_assign_i = 2'h0, ctrl_o;
  logic [15:0] transfer_normal_i = 16'h0000, transfer_upper_i = 16'h0000, transfer_o;
  logic [15:0] heat_mv_i = 16'h0000, cool_mv_i = 16'h0000, manual_mv_i = 16'h0000;
  logic [15:0] output_value_while_reset_i = 16'h0000, heat_mv_o, cool_mv_o;
  logic [15:0] output_value_on_process_fault_i = 16'h0000;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  ifs_sensor_model model (.clock_i, .temp_i(temp), .open_i(sensor_open_i), .pv_o(pv_i));

  ifs_supervisor DUT (.clock_i, .reset_n_i, .input_type_i, .fahrenheit_i, .pv_i, .sp_low_i,
    .sp_high_i, .scale_low_i, .scale_high_i, .ind_low_i, .ind_high_i, .type_mismatch_i,
    .sensor_open_i, .sensor_short_i, .rtd_line_open_i, .converter_fault_i, .alarm_normal_i,
    .alarm_upper_i, .aux_normal_i, .aux_fault_assign_i, .ctrl_normal_i, .ctrl_fault_assign_i,
    .transfer_normal_i, .transfer_upper_i, .heat_mv_i, .cool_mv_i, .manual_mode_i,
    .manual_mv_i, .in_reset_i, .value_while_reset_en_i, .output_value_while_reset_i,
    .value_on_fault_en_i, .output_value_on_process_fault_i, .input_fault_o,
    .converter_fault_code_o, .fault_cause_o, .disp_code_o, .disp_value_o, .alarm_o, .aux_o,
    .ctrl_o, .transfer_o, .heat_mv_o, .cool_mv_o);

  always #5 clock_i = ~clock_i;

  ////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("Counts: comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Outputs answer one edge after the inputs are taken
  task automatic step();
    @(posedge clock_i);
    #1;
  endtask : step

  task automatic pattern(input logic [3:0] k);
    alarm_normal_i <= k;
    alarm_upper_i <= ~k;
    aux_normal_i <= k ^ 4'h6;
    aux_fault_assign_i <= ~k ^ 4'h6;
    ctrl_normal_i <= k[1:0];
    ctrl_fault_assign_i <= ~k[1:0];
    transfer_normal_i <= {4{k}};
    transfer_upper_i <= {4{~k}};
    heat_mv_i <= {k, 12'h011};
    cool_mv_i <= {k, 12'h022};
    manual_mv_i <= 16'h0033;
    output_value_while_reset_i <= 16'h0044;
    output_value_on_process_fault_i <= 16'h0055;
  endtask : pattern

  task automatic chk_normal();
    chk(alarm_o, alarm_normal_i);
    chk(aux_o, aux_normal_i);
    chk(ctrl_o, ctrl_normal_i);
    chk(transfer_o, transfer_normal_i);
    chk(heat_mv_o, heat_mv_i);
    chk(cool_mv_o, cool_mv_i);
  endtask : chk_normal

  task automatic range_pt(input ifs_input_type t, input logic f, input int v, input logic e);
    @(posedge clock_i);
    input_type_i <= t;
    fahrenheit_i <= f;
    temp <= v[15:0];
    step();
    chk(input_fault_o, e);
    chk(fault_cause_o[CAUSE_RANGE], e);
  endtask : range_pt

  ////////////////////////////////////////////////////////////////
  task automatic test_reset();
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    pattern(4'h3);
    #1;
    chk({input_fault_o, converter_fault_code_o, fault_cause_o, alarm_o, aux_o, ctrl_o,
      transfer_o}, 32'h0000_0000);
    chk({heat_mv_o, cool_mv_o}, 32'h0000_0000);
    chk(disp_value_o[15:0], 16'h0000);
    chk(disp_code_o, IFS_DISP_NUMERIC);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_range();
    range_pt(IFS_IN_THERMOCOUPLE, 1'b0, 120, 1'b0);
    range_pt(IFS_IN_THERMOCOUPLE, 1'b0, 121, 1'b1);
    range_pt(IFS_IN_RESISTANCE, 1'b0, -20, 1'b0);
    range_pt(IFS_IN_RESISTANCE, 1'b0, -21, 1'b1);
    range_pt(IFS_IN_THERMOCOUPLE, 1'b1, 140, 1'b0);
    range_pt(IFS_IN_THERMOCOUPLE, 1'b1, 141, 1'b1);
    range_pt(IFS_IN_ANALOG, 1'b0, 1050, 1'b0);
    range_pt(IFS_IN_ANALOG, 1'b0, 1051, 1'b1);
    range_pt(IFS_IN_ANALOG, 1'b0, -50, 1'b0);
    range_pt(IFS_IN_ANALOG, 1'b0, -51, 1'b1);
    range_pt(IFS_IN_INFRARED, 1'b0, 500, 1'b0);
    range_pt(IFS_IN_INFRARED, 1'b0, 501, 1'b1);
    range_pt(IFS_IN_INFRARED, 1'b0, -101, 1'b1);
    range_pt(IFS_IN_RESISTANCE, 1'b0, 50, 1'b0);
    $display("test_range done");
  endtask : test_range

  task automatic test_causes();
    int bitpos[6] = '{CAUSE_TYPE, CAUSE_OPEN, CAUSE_SHORT, CAUSE_OPEN, CAUSE_OPEN, CAUSE_OPEN};
    for (int k = 0; k < 6; k++) begin
      @(posedge clock_i);
      type_mismatch_i <= (k == 0);
      sensor_open_i <= (k == 1);
      sensor_short_i <= (k == 2);
      rtd_line_open_i <= (k > 2) ? 3'h1 << (k - 3) : 3'h0;
      step();
      chk(input_fault_o, 1'b1);
      chk(fault_cause_o[bitpos[k]], 1'b1);
    end
    @(posedge clock_i);
    input_type_i <= IFS_IN_THERMOCOUPLE;
    step();
    chk(input_fault_o, 1'b0);
    @(posedge clock_i);
    rtd_line_open_i <= 3'h0;
    $display("test_causes done");
  endtask : test_causes

  task automatic test_effects();
    logic [15:0] hold[4] = '{16'h0000, 16'h0055, 16'h0044, 16'h0033};
    @(posedge clock_i);
    pattern(4'h5);
    sensor_short_i <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clock_i);
      value_on_fault_en_i <= (m >= 1);
      in_reset_i <= (m >= 2);
      value_while_reset_en_i <= (m >= 2);
      manual_mode_i <= (m == 3);
      step();
      chk(alarm_o, alarm_upper_i);
      chk(transfer_o, transfer_upper_i);
      chk(aux_o & aux_fault_assign_i, aux_fault_assign_i);
      chk(ctrl_o, ctrl_fault_assign_i);
      chk(disp_code_o, IFS_DISP_INPUT_FAULT);
      chk(heat_mv_o, hold[m]);
      chk(cool_mv_o, 16'h0000);
    end
    @(posedge clock_i);
    {value_on_fault_en_i, in_reset_i, value_while_reset_en_i, manual_mode_i} <= 4'h0;
    sensor_short_i <= 1'b0;
    step();
    chk_normal();
    $display("test_effects done");
  endtask : test_effects

  task automatic test_display();
    int vals[4] = '{-2000, -1999, 9999, 10000};
    ifs_disp_type codes[4] = '{IFS_DISP_UNDER, IFS_DISP_NUMERIC, IFS_DISP_NUMERIC, IFS_DISP_OVER};
    @(posedge clock_i);
    pattern(4'ha);
    sp_low_i <= 16'hf7cc;
    sp_high_i <= 16'h2774;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock_i);
      temp <= vals[k][15:0];
      step();
      chk(disp_code_o, codes[k]);
      chk(disp_value_o[15:0], vals[k][15:0]);
      chk(input_fault_o, 1'b0);
      chk_normal();
    end
    $display("test_display done");
  endtask : test_display

  task automatic test_converter();
    @(posedge clock_i);
    temp <= 16'h0032;
    converter_fault_i <= 1'b1;
    sensor_short_i <= 1'b1;
    step();
    chk(converter_fault_code_o, 1'b1);
    chk(disp_code_o, IFS_DISP_CONVERTER_FAULT);
    chk({alarm_o, aux_o, ctrl_o, transfer_o}, 32'h0000_0000);
    chk({heat_mv_o, cool_mv_o}, 32'h0000_0000);
    chk(fault_cause_o, 4'h8);
    @(posedge clock_i);
    {converter_fault_i, sensor_short_i} <= 2'h0;
    step();
    chk(converter_fault_code_o, 1'b0);
    chk_normal();
    $display("test_converter done");
  endtask : test_converter

  ////////////////////////////////////////////////////////////////
  initial begin
    test_reset();
    test_range();
    test_causes();
    test_effects();
    test_display();
    test_converter();
    end_sim();
  end
endmodule : test_input_fault_supervisor
